// File: common/nbu_uart_regs.vh
`ifndef NBU_UART_REGS_VH
`define NBU_UART_REGS_VH
// register indices, byte address is four times the index
`define NBU_IDX_PWR 8'h87
`define NBU_IDX_SCTL 8'h98
`define NBU_IDX_BUF 8'h99
`define NBU_IDX_FRAC 8'h9D
`define NBU_IDX_RATE 8'h9E
`define NBU_IDX_T2CTL 8'hC8
`define NBU_IDX_CFG 8'hAF
`define NBU_IDX_T1REL 8'hB0
`define NBU_IDX_T2RELL 8'hB1
`define NBU_IDX_T2RELH 8'hB2
// power_control fields
`define NBU_PWR_RATE_DOUBLE 7
// serial_control fields
`define NBU_SC_MODE_HI 7
`define NBU_SC_MODE_LO 6
`define NBU_SC_MP_FILTER 5
`define NBU_SC_RX_EN 4
`define NBU_SC_TX_NINTH 3
`define NBU_SC_RX_NINTH 2
`define NBU_SC_TX_DONE 1
`define NBU_SC_RX_DONE 0
// fraction_divider fields
`define NBU_FD_TIMER_EN 7
// timer_two_ctrl fields
`define NBU_T2_RX_SEL 5
`define NBU_T2_TX_SEL 4
// config fields
`define NBU_CFG_EXT_RX 0
`define NBU_CFG_OVERWRITE 1
// reset values
`define NBU_RST_REG8 8'h00
`define NBU_RST_REL16 16'h0000
// timing counts
`define NBU_SHIFT_DIV 4'd12
`define NBU_SHIFT_HALF 4'd6
`define NBU_SHIFT_SAMPLE 4'd10
`define NBU_OVS_LAST 4'd15
`define NBU_START_CHECK 4'd7
`define NBU_FRAC_ONE 18'd64
`endif

// File: hdl/nbu_uart_core.v
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "nbu_uart_regs.vh"

// Notes on behaviour
// RULE1 - mode bits 10 select fixed-rate 9-bit
// RULE2 - fixed rate: clock/32, or /16 doubled
// RULE3 - frame: start, eight data LSB first, ninth, stop
// RULE4 - tx shifter takes buffer and tx ninth bit
// RULE5 - tx starts only at next bit tick
// RULE6 - tx done set as stop bit appears
// RULE7 - plain receiver needs rx done clear
// RULE8 - multiproc filter keeps ninth-bit-one frames only
// RULE9 - failed frame dropped, rx done untouched
// RULE10 - accept: buffer, ninth bit, set rx done
// RULE11 - mode bits 11: 9-bit at variable rate
// RULE12 - variable rate from t1, t2 or timer
// RULE13 - any buffer write starts a transmission
// RULE14 - rx start: shift mode flag, else start bit
// RULE15 - shift-register mode runs at clock/12
// RULE16 - t1 rate: overflow times 2^double over 32
// RULE17 - t2 rate: sixteen overflows per bit
// RULE18 - t2 counts once per two clocks
// RULE19 - t2 drives tx and/or rx by selects
// RULE20 - timer exponent is div plus extended field
// RULE21 - timer bit: 16*2^exp*(1+frac/64) clocks
// RULE22 - timer enable overrides double and t2 selects
// RULE23 - extended rx accepts even with rx done set, flags overwrite
// RULE24 - sixteen-times sampling, start checked mid-bit
// RULE25 - buffer writes tx holding, reads rx holding
module nbu_uart_core (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // serial pins
  output reg txd,
  input wire rxd_in,
  output reg rxd_out,
  output reg rxd_oe_n
);

  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;

  reg [7:0] pwr_ctrl;
  reg [7:0] sctl;
  reg [7:0] rx_buf;
  reg [7:0] tx_hold;
  reg [7:0] frac_div;
  reg [4:0] rate_ctrl;
  reg [7:0] t2ctl;
  reg [1:0] cfg;
  reg [7:0] t1_reload_value;
  reg [15:0] t2_reload;
  reg [7:0] rd_mux;
  reg hit;
  reg rxd_s1;
  reg rxd_s2;
  reg [7:0] t1_cnt;
  reg t1_half;
  reg [15:0] t2_cnt;
  reg t2_pre;
  reg [17:0] ded_acc;
  reg fix_pre;
  reg [3:0] m0_cnt;
  reg [3:0] tx_sub;
  reg [3:0] rx_sub;
  reg tx_busy;
  reg tx_pending;
  reg [9:0] tx_shift;
  reg [3:0] tx_cnt;
  reg [1:0] rx_state;
  reg [3:0] rx_cnt;
  reg [7:0] rx_shift;
  reg m0_rx_busy;

  wire [7:0] idx = paddr[9:2];
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite & hit;
  wire rd = access & ~pwrite & hit;
  wire buf_wr = wr & (idx == `NBU_IDX_BUF);
  wire buf_rd = rd & (idx == `NBU_IDX_BUF);
  wire [1:0] mode = {sctl[`NBU_SC_MODE_HI], sctl[`NBU_SC_MODE_LO]};
  wire mode0 = (mode == 2'b00);
  wire ext_rx = cfg[`NBU_CFG_EXT_RX];
  wire ri = sctl[`NBU_SC_RX_DONE];
  wire timer_en = frac_div[`NBU_FD_TIMER_EN];
  // timer enable masks rate double and both t2 selects
  // RULE22 override bits
  wire dbl = pwr_ctrl[`NBU_PWR_RATE_DOUBLE] & ~timer_en;
  wire t2_tx = t2ctl[`NBU_T2_TX_SEL] & ~timer_en;
  wire t2_rx = t2ctl[`NBU_T2_RX_SEL] & ~timer_en;
  wire t1_ovf = (t1_cnt == 8'hFF);
  wire t2_ovf = t2_pre & (t2_cnt == 16'hFFFF) & (t2_tx | t2_rx);
  wire t1_tick = t1_ovf & (dbl | t1_half);
  wire fix_tick = dbl | fix_pre;
  wire [3:0] exp_sum = {1'b0, rate_ctrl[2:0]} + {2'b00, rate_ctrl[4:3]};
  wire [17:0] ded_lim = {11'h000, 1'b1, frac_div[5:0]} << exp_sum;
  wire [17:0] ded_sum = ded_acc + `NBU_FRAC_ONE;
  wire ded_tick = (ded_sum >= ded_lim);
  wire m0_bound = (m0_cnt == `NBU_SHIFT_DIV - 4'd1);
  wire [3:0] n_last = (mode == 2'b01) ? 4'd8 : 4'd9;

  // per-direction sixteen-times tick source
  // RULE1 RULE2 fixed pick
  // RULE11 RULE12 RULE19 variable pick
  reg tx_tick;
  reg rx_tick;
  always @* begin
    if (mode == 2'b10) begin
      tx_tick = fix_tick;
      rx_tick = fix_tick;
    end else if (timer_en) begin
      tx_tick = ded_tick;
      rx_tick = ded_tick;
    end else begin
      tx_tick = t2_tx ? t2_ovf : t1_tick;
      rx_tick = t2_rx ? t2_ovf : t1_tick;
    end
  end

  wire tx_bit = tx_tick & (tx_sub == `NBU_OVS_LAST);
  // RULE6 done at stop
  wire ti_set = (~mode0 & tx_busy & tx_bit & (tx_cnt == n_last)) |
    (mode0 & tx_busy & m0_bound & (tx_cnt == 4'd7));
  wire rx_final = ~mode0 & (rx_state == RX_DATA) & rx_tick &
    (rx_sub == `NBU_OVS_LAST) & (rx_cnt == 4'd8);
  // RULE7 RULE8 RULE23 acceptance
  wire rx_ok = (ext_rx | ~ri) &
    (~sctl[`NBU_SC_MP_FILTER] | rxd_s2);
  wire rx_accept = rx_final & rx_ok;
  wire m0_rx_done = m0_rx_busy & m0_bound & (rx_cnt == 4'd8);

  // zero-wait slave, unmapped index answers with an error
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // read mux and decode, unused frac, rate and cfg bits read as zero
  // RULE25 rx holding read
  always @* begin
    hit = 1'b1;
    rd_mux = 8'h00;
    case (idx)
      `NBU_IDX_PWR: rd_mux = pwr_ctrl;
      `NBU_IDX_SCTL: rd_mux = sctl;
      `NBU_IDX_BUF: rd_mux = rx_buf;
      `NBU_IDX_FRAC: rd_mux = {frac_div[7], 1'b0, frac_div[5:0]};
      `NBU_IDX_RATE: rd_mux = {3'b000, rate_ctrl};
      `NBU_IDX_T2CTL: rd_mux = t2ctl;
      `NBU_IDX_CFG: rd_mux = {6'h00, cfg};
      `NBU_IDX_T1REL: rd_mux = t1_reload_value;
      `NBU_IDX_T2RELL: rd_mux = t2_reload[7:0];
      `NBU_IDX_T2RELH: rd_mux = t2_reload[15:8];
      default: hit = 1'b0;
    endcase
  end

  // read data captured in the setup phase so it comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= {24'h000000, rd_mux};
    end
  end

  // register file; hardware sets are placed last so they win
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ctrl <= `NBU_RST_REG8;
      sctl <= `NBU_RST_REG8;
      rx_buf <= `NBU_RST_REG8;
      tx_hold <= `NBU_RST_REG8;
      frac_div <= `NBU_RST_REG8;
      rate_ctrl <= 5'h00;
      t2ctl <= `NBU_RST_REG8;
      cfg <= 2'b00;
      t1_reload_value <= `NBU_RST_REG8;
      t2_reload <= `NBU_RST_REL16;
    end else begin
      if (wr) begin
        case (idx)
          `NBU_IDX_PWR: pwr_ctrl <= pwdata[7:0];
          `NBU_IDX_SCTL: sctl <= pwdata[7:0];
          // RULE25 tx holding write
          `NBU_IDX_BUF: tx_hold <= pwdata[7:0];
          `NBU_IDX_FRAC: frac_div <= pwdata[7:0];
          `NBU_IDX_RATE: rate_ctrl <= pwdata[4:0];
          `NBU_IDX_T2CTL: t2ctl <= pwdata[7:0];
          `NBU_IDX_CFG: cfg[`NBU_CFG_EXT_RX] <= pwdata[0];
          `NBU_IDX_T1REL: t1_reload_value <= pwdata[7:0];
          `NBU_IDX_T2RELL: t2_reload[7:0] <= pwdata[7:0];
          `NBU_IDX_T2RELH: t2_reload[15:8] <= pwdata[7:0];
          default: ;
        endcase
      end
      // overwrite flag clears on a buffer read
      if (buf_rd) begin
        cfg[`NBU_CFG_OVERWRITE] <= 1'b0;
      end
      if (ti_set) begin
        sctl[`NBU_SC_TX_DONE] <= 1'b1;
      end
      // RULE10 accept store
      // RULE9 drop keeps flag
      if (rx_accept) begin
        rx_buf <= rx_shift;
        sctl[`NBU_SC_RX_NINTH] <= rxd_s2;
        sctl[`NBU_SC_RX_DONE] <= 1'b1;
      end
      // RULE23 overwrite flag
      if (rx_accept & ext_rx & ri) begin
        cfg[`NBU_CFG_OVERWRITE] <= 1'b1;
      end
      if (m0_rx_done) begin
        rx_buf <= rx_shift;
        sctl[`NBU_SC_RX_DONE] <= 1'b1;
      end
    end
  end

  // pin synchroniser, only the second stage is read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= rxd_in;
      rxd_s2 <= rxd_s1;
    end
  end

  // rate sources: t1 per clock, t2 per two clocks, fractional timer
  // RULE16 t1 autoreload
  // RULE17 RULE18 t2 half rate
  // RULE20 RULE21 fractional acc
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_cnt <= 8'h00;
      t1_half <= 1'b0;
      t2_cnt <= 16'h0000;
      t2_pre <= 1'b0;
      ded_acc <= 18'h00000;
      fix_pre <= 1'b0;
      m0_cnt <= 4'h0;
    end else begin
      t1_cnt <= t1_ovf ? t1_reload_value : t1_cnt + 8'h01;
      if (t1_ovf) begin
        t1_half <= ~t1_half;
      end
      t2_pre <= ~t2_pre;
      if (t2_pre) begin
        t2_cnt <= (t2_cnt == 16'hFFFF) ? t2_reload : t2_cnt + 16'h0001;
      end
      // accumulator averages the fraction without drift
      ded_acc <= ded_tick ? ded_sum - ded_lim : ded_sum;
      fix_pre <= ~fix_pre;
      // RULE15 twelve clock shift
      m0_cnt <= m0_bound ? 4'h0 : m0_cnt + 4'h1;
    end
  end

  // transmitter: async frames and shift-register mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_n <= 1'b1;
      tx_busy <= 1'b0;
      tx_pending <= 1'b0;
      tx_shift <= 10'h3FF;
      tx_cnt <= 4'h0;
      tx_sub <= 4'h0;
    end else begin
      if (tx_tick) begin
        tx_sub <= tx_sub + 4'h1;
      end
      if (mode0) begin
        // shift clock low for the first half of each bit
        txd <= ~((tx_busy | m0_rx_busy) & (m0_cnt < `NBU_SHIFT_HALF));
        if (m0_bound) begin
          if (!tx_busy && tx_pending && !m0_rx_busy) begin
            tx_busy <= 1'b1;
            tx_pending <= 1'b0;
            rxd_oe_n <= 1'b0;
            rxd_out <= tx_hold[0];
            tx_shift <= {2'b11, tx_hold};
            tx_cnt <= 4'h0;
          end else if (tx_busy && tx_cnt == 4'd7) begin
            tx_busy <= 1'b0;
            rxd_oe_n <= 1'b1;
            rxd_out <= 1'b1;
          end else if (tx_busy) begin
            rxd_out <= tx_shift[1];
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_cnt <= tx_cnt + 4'h1;
          end
        end
      end else if (tx_bit) begin
        // RULE5 wait bit tick
        if (!tx_busy && tx_pending) begin
          // RULE3 RULE4 frame load
          tx_busy <= 1'b1;
          tx_pending <= 1'b0;
          txd <= 1'b0;
          tx_shift <= {1'b1, (mode == 2'b01) | sctl[`NBU_SC_TX_NINTH],
            tx_hold};
          tx_cnt <= 4'h0;
        end else if (tx_busy && tx_cnt == n_last + 4'd1) begin
          tx_busy <= 1'b0;
          txd <= 1'b1;
        end else if (tx_busy) begin
          txd <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_cnt <= tx_cnt + 4'h1;
        end
      end
      // RULE13 buffer write starts
      if (buf_wr) begin
        tx_pending <= 1'b1;
      end
    end
  end

  // receiver: sixteen-times sampling, plus shift-register reception
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_sub <= 4'h0;
      rx_cnt <= 4'h0;
      rx_shift <= 8'h00;
      m0_rx_busy <= 1'b0;
    end else if (mode0) begin
      rx_state <= RX_IDLE;
      // RULE14 shift-mode start
      if (m0_bound && !m0_rx_busy && !tx_busy && !tx_pending &&
          sctl[`NBU_SC_RX_EN] && !ri) begin
        m0_rx_busy <= 1'b1;
        rx_cnt <= 4'h0;
      end else if (m0_rx_done) begin
        m0_rx_busy <= 1'b0;
      end else if (m0_rx_busy && m0_cnt == `NBU_SHIFT_SAMPLE) begin
        rx_shift <= {rxd_s2, rx_shift[7:1]};
        rx_cnt <= rx_cnt + 4'h1;
      end
    end else begin
      m0_rx_busy <= 1'b0;
      if (rx_tick) begin
        case (rx_state)
          RX_IDLE: begin
            // RULE14 start bit
            if (sctl[`NBU_SC_RX_EN] && !rxd_s2) begin
              rx_state <= RX_START;
              rx_sub <= 4'h0;
            end
          end
          RX_START: begin
            rx_sub <= rx_sub + 4'h1;
            // RULE24 mid start check
            if (rx_sub == `NBU_START_CHECK) begin
              rx_state <= rxd_s2 ? RX_IDLE : RX_DATA;
              rx_sub <= 4'h0;
              rx_cnt <= 4'h0;
            end
          end
          RX_DATA: begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `NBU_OVS_LAST) begin
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_cnt == 4'd8) begin
                rx_state <= RX_IDLE;
              end else begin
                rx_shift <= {rxd_s2, rx_shift[7:1]};
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

endmodule // nbu_uart_core

// File: testbench/nbu_remote_node.sv
`timescale 1ns/100ps

// remote node: captures device frames and sends frames back
module nbu_remote_node #(
  parameter int BIT = 16
) (
  // clock and line pins
  input wire logic pclk,
  input wire logic txd,
  output logic rxd_in
);
  logic [9:0] rx_q[$];
  logic [9:0] w;
  int i;

  initial begin
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge pclk);
      for (i = 0; i < 10; i++) begin
        repeat (BIT) @(posedge pclk);
        w[i] = txd;
      end
      rx_q.push_back(w);
    end
  end

  task automatic send(input logic [8:0] v, input int gap);
    int k;
    begin
      repeat (gap) @(posedge pclk);
      rxd_in <= 1'b0;
      for (k = 0; k < 10; k++) begin
        repeat (BIT) @(posedge pclk);
        rxd_in <= (k == 9) ? 1'b1 : v[k];
      end
      repeat (BIT) @(posedge pclk);
    end
  endtask

  // line idles high, as a pulled-up link does
  initial rxd_in = 1'b1;
endmodule // nbu_remote_node

// File: testbench/nbu_uart_core_properties.sv
`timescale 1ns/100ps
`include "nbu_uart_regs.vh"

// port-level checks on the apb slave and the serial pins
module nbu_uart_core_properties (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial side
  input wire logic txd,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready; pready; endproperty
  a_ready: assert property (p_ready)
    else $error("pready dropped");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error outside access phase");
  property p_unmapped; psel && penable && paddr[9:2] == 8'h00 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped slot not refused");
  property p_mapped;
    psel && penable && paddr[9:2] == `NBU_IDX_BUF |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("buffer slot refused");
  property p_err_zero; psel && penable && !pwrite && pslverr |-> prdata == 0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read not zero");
  property p_upper; psel && penable && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("read data upper bits set");
  property p_start_len; $fell(txd) |-> !txd [*6]; endproperty
  a_start_len: assert property (p_start_len)
    else $error("start bit too short");
  property p_idle; $rose(presetn) |-> txd && rxd_out && rxd_oe_n; endproperty
  a_idle: assert property (p_idle)
    else $error("serial pins not idle after reset");
endmodule // nbu_uart_core_properties

bind nbu_uart_core nbu_uart_core_properties i_nbu_uart_core_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd), .rxd_in(rxd_in),
  .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n));

// File: testbench/nine_bit_uart_baud_gen_tb.sv
`timescale 1ns/100ps
`include "nbu_uart_regs.vh"

// bench: apb master, reference model and remote node
module nine_bit_uart_baud_gen_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic txd, rxd_in, rxd_out, rxd_oe_n;
  int mismatches, n_compared, i, n, m_buf, m_nin, m_rxdone, filt, nin, d;
  int m0_got;
  realtime t0;
  int unsigned seed = 63;

  nbu_uart_core i_nbu_uart_core (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n));
  nbu_remote_node #(.BIT(16)) i_nbu_remote_node (.pclk(pclk), .txd(txd),
    .rxd_in(rxd_in));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; idle cycle after so psel never toggles twice
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no local limit: only the watchdog ends a stuck wait
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic do_tx(input logic [7:0] ctl, input logic nb);
    logic [7:0] dt;
    logic [9:0] got;
    begin
      dt = 8'(xs());
      apb(1'b1, `NBU_IDX_SCTL, ctl | {4'h0, nb, 3'h0});
      apb(1'b1, `NBU_IDX_BUF, dt);
      n = 0;
      while (i_nbu_remote_node.rx_q.size() == 0 && n < 800) begin
        @(posedge pclk);
        n++;
      end
      check("tx_count", i_nbu_remote_node.rx_q.size(), 1);
      got = 10'h000;
      if (n < 800) got = i_nbu_remote_node.rx_q.pop_front();
      check("tx_frame", got, {1'b1, nb, dt});
      apb(1'b0, `NBU_IDX_SCTL, 8'h00);
      check("tx_done", rd[1], 1'b1);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; mismatches = 0; n_compared = 0;
    m_buf = 0; m_nin = 0; m_rxdone = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `NBU_IDX_SCTL, 8'h00);
    check("sctl_reset", rd, 0);
    apb(1'b0, 8'h00, 8'h00);
    check("unmapped_err", err, 1);
    check("unmapped_rd", rd, 0);
    apb(1'b1, `NBU_IDX_PWR, 8'h80);
    do_tx(8'h90, 1'b0);
    do_tx(8'h90, 1'b1);
    // accept, busy drop, filter drop, filter pass
    for (i = 0; i < 4; i++) begin
      filt = (i >= 2);
      nin = (i == 0 || i == 3);
      if (i != 1) m_rxdone = 0;
      // keep the stored ninth bit, a control write would clear it
      apb(1'b1, `NBU_IDX_SCTL,
          8'(8'h90 | (filt << 5) | (m_nin << 2) | m_rxdone));
      d = xs() % 256;
      i_nbu_remote_node.send({nin[0], d[7:0]}, i * 7);
      if (m_rxdone == 0 && (filt == 0 || nin == 1)) begin
        m_buf = d;
        m_nin = nin;
        m_rxdone = 1;
      end
      apb(1'b0, `NBU_IDX_SCTL, 8'h00);
      check("rx_done", rd[0], m_rxdone);
      check("rx_ninth", rd[2], m_nin);
      apb(1'b0, `NBU_IDX_BUF, 8'h00);
      check("rx_buf", rd, m_buf);
    end
    // extended receiver takes a frame over a set flag
    apb(1'b1, `NBU_IDX_CFG, 8'h01);
    apb(1'b1, `NBU_IDX_SCTL, 8'h95);
    d = xs() % 256;
    i_nbu_remote_node.send({1'b0, d[7:0]}, 3);
    apb(1'b0, `NBU_IDX_CFG, 8'h00);
    check("ovw_flag", rd, 32'h00000003);
    apb(1'b0, `NBU_IDX_BUF, 8'h00);
    check("ovw_buf", rd, d);
    apb(1'b0, `NBU_IDX_CFG, 8'h00);
    check("ovw_clear", rd, 32'h00000001);
    apb(1'b1, `NBU_IDX_CFG, 8'h00);
    apb(1'b1, `NBU_IDX_FRAC, 8'hFF);
    apb(1'b0, `NBU_IDX_FRAC, 8'h00);
    check("frac_rb", rd, 32'h000000BF);
    apb(1'b1, `NBU_IDX_RATE, 8'hFF);
    apb(1'b0, `NBU_IDX_RATE, 8'h00);
    check("rate_rb", rd, 32'h0000001F);
    // exponent 0, fraction 0: 16-clock bits
    apb(1'b1, `NBU_IDX_RATE, 8'h00);
    apb(1'b1, `NBU_IDX_FRAC, 8'h80);
    do_tx(8'hD0, 1'b1);
    // t1 reload 0xFF with rate double: a tick per clock
    repeat (16) @(posedge pclk);
    apb(1'b1, `NBU_IDX_FRAC, 8'h00);
    apb(1'b1, `NBU_IDX_T1REL, 8'hFF);
    do_tx(8'hD0, 1'b0);
    // shift mode: eight bits on rxd, twelve clocks apart
    repeat (32) @(posedge pclk);
    apb(1'b1, `NBU_IDX_SCTL, 8'h00);
    d = xs() % 256;
    apb(1'b1, `NBU_IDX_BUF, d[7:0]);
    m0_got = 0;
    for (i = 0; i < 8; i++) begin
      @(posedge txd);
      if (i > 0)
        check("m0_period", int'(($realtime - t0) / 25.0), 12);
      t0 = $realtime;
      check("m0_drive", rxd_oe_n, 1'b0);
      m0_got[i] = rxd_out;
    end
    check("m0_data", m0_got, d);
    repeat (8) @(posedge pclk);
    check("m0_release", rxd_oe_n, 1'b1);
    apb(1'b0, `NBU_IDX_SCTL, 8'h00);
    check("m0_done", rd[1], 1'b1);
    close_out;
  end

  // watchdog: the run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    close_out;
  end
endmodule // nine_bit_uart_baud_gen_tb
